/* rtl/seqclk_divider.sv */
`timescale 1ns/1ps
`default_nettype none
module seqclk_divider
(
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_xtal_clk,
    input  wire logic        i_rc_clk,
    input  wire logic        i_window_done,
    input  wire logic        i_run,
    input  wire logic [5:0]  i_setting,
    output logic             o_clk
);
    import seqclk_pkg::*;

    logic [3:0] ratio;
    logic [1:0] mode;
    logic [4:0] count;
    logic       phase;
    logic       xtal_d;
    logic [3:0] next_ratio;
    logic [1:0] next_mode;
    logic [4:0] next_count;
    logic       next_phase;
    logic       next_out;
    logic       boundary;
    logic       rise;

    assign rise = i_xtal_clk & ~xtal_d;

    always_comb
    begin
        next_ratio = ratio;
        next_mode  = mode;
        next_count = count;
        next_phase = phase;
        boundary   = 1'b0;
        if (rise)
        begin
            // half period is ratio+1 crystal edges
            if (count == {1'b0, ratio})
            begin
                next_count = 5'h00;
                next_phase = ~phase;
                boundary   = phase;
            end
            else
            begin
                next_count = count + 5'h01;
            end
        end
        if (boundary)
        begin
            next_ratio = i_setting[3:0];
            next_mode  = i_setting[5:4];
        end
        // new source applied in the boundary cycle itself, no runt pulse
        unique case (seqclk_src_t'(next_mode))
            SCK_SRC_DIV:    next_out = next_phase;
            SCK_SRC_XTAL:   next_out = i_xtal_clk;
            SCK_SRC_RC:     next_out = i_rc_clk;
            SCK_SRC_WINDOW: next_out = i_window_done;
        endcase
        if (!i_run)
        begin
            next_out = 1'b0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ratio  <= CLOCK_DIV_RESET[3:0];
            mode   <= CLOCK_DIV_RESET[5:4];
            count  <= 5'h00;
            phase  <= 1'b0;
            xtal_d <= 1'b0;
            o_clk  <= 1'b0;
        end
        else
        begin
            ratio  <= next_ratio;
            mode   <= next_mode;
            count  <= next_count;
            phase  <= next_phase;
            xtal_d <= i_xtal_clk;
            o_clk  <= next_out;
        end
    end
endmodule
`default_nettype wire

/* rtl/seqclk_pkg.sv */
package seqclk_pkg;

    // register offsets
    localparam logic [7:0] ADDR_CONFIG     = 8'h00;
    localparam logic [7:0] ADDR_ADC_SELECT = 8'h08;
    localparam logic [7:0] ADDR_CLOCK_DIV  = 8'h0d;
    localparam logic [7:0] ADDR_BLOCK_POWERDOWN_OVERRIDE   = 8'h0f;
    localparam logic [7:0] ADDR_ADC_RESULT = 8'h81;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'hc0;

    // config fields (16-bit register)
    localparam int CFG_CLK_IN_PD_BIT = 9;
    localparam int CFG_TESTMODE_BIT  = 0;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;

    // adc select fields
    localparam int SEL_BIT = 6;
    localparam logic [7:0] ADC_SELECT_RESET = 8'hff;

    // divider fields
    localparam int DIV_MODE_LSB  = 4;
    localparam int DIV_RATIO_LSB = 0;
    localparam logic [7:0] CLOCK_DIV_RESET = 8'h08;

    // block power-down override
    localparam logic [15:0] BLOCK_POWERDOWN_OVERRIDE_RESET = 16'hffff;
    localparam int PD_ADC_BIT  = 12;
    localparam int PD_PA_BIT   = 2;
    localparam int PD_XTAL_BIT = 0;

    // adc result fields
    localparam int RES_PD_BIT  = 7;
    localparam int RES_SEL_BIT = 6;

    // output source codes
    typedef enum logic [1:0]
    {
        SCK_SRC_DIV    = 2'b00,
        SCK_SRC_XTAL   = 2'b01,
        SCK_SRC_RC     = 2'b10,
        SCK_SRC_WINDOW = 2'b11
    } seqclk_src_t;

    // timing, in rc oscillator ticks (32 kHz, 31.25 us)
    localparam int RC_TICK_NS       = 31250;
    localparam int CLOCK_SETTLE_US  = 500;
    localparam int SYS_SETUP_US     = 2600;
    localparam int DETECT_SETUP_US  = 2600;
    localparam int TX_SETUP_US      = 1000;
    localparam int CLOCK_SETTLE_TICKS =
        (CLOCK_SETTLE_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
    localparam int SYS_SETUP_TICKS =
        (SYS_SETUP_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
    localparam int DETECT_SETUP_TICKS =
        (DETECT_SETUP_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
    localparam int TX_SETUP_TICKS =
        (TX_SETUP_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } seqclk_bus_t;

    typedef struct packed
    {
        logic xtal_en;
        logic adc_en;
        logic detect_en;
        logic pa_en;
        logic rx_ready;
    } seqclk_enables_t;

endpackage

/* rtl/seqclk_top.sv */
// Behaviour
// - all sequencing timed by rc oscillator ticks; drives analog enables
// - after reset the output clock runs at the default 1 MHz ratio
// - clock marked valid only after settle time from xtal enable
// - detect pin low at start: normal timing after system setup time
// - detect pin high at start: clock runs, wait pin low then setup
// - clock stopped in power-down unless clock-in-power-down bit set
// - detection starts detect setup time after receive activation
// - power amplifier enabled transmit setup time after transmit activation
// - test mode: override register drives block enables directly
// - output-select bits choose divider, crystal, rc or window signal
// - select bit picks supply/5 (0) or rssi (1) for the adc
// - result upper bits show power-down and select of that sample
// - result: bit7 power-down, bit6 select, bits5-0 measurement
`timescale 1ns/1ps
`default_nettype none
module seqclk_top
(
    input  wire logic                        i_clock,
    input  wire logic                        i_rst,
    input  wire seqclk_pkg::seqclk_bus_t     i_bus,
    output logic [15:0]                      o_rdata,
    input  wire logic                        i_powerdown_detect_pin,
    input  wire logic                        i_rx_mode,
    input  wire logic                        i_rc_clk,
    input  wire logic                        i_xtal_clk,
    input  wire logic                        i_window_done,
    input  wire logic                        i_adc_sample,
    input  wire logic [5:0]                  i_adc_value,
    output logic                             o_divided_clock_pin,
    output logic                             o_clock_valid,
    output logic                             o_normal_timing,
    output seqclk_pkg::seqclk_enables_t      o_enables,
    output logic                             o_adc_use_rssi
);
    import seqclk_pkg::*;

    typedef enum logic [2:0]
    {
        ST_START,
        ST_WAIT_LOW,
        ST_SETUP,
        ST_POWERDOWN,
        ST_RX_SETUP,
        ST_RX,
        ST_TX_SETUP,
        ST_TX
    } seqclk_state_t;

    function automatic logic sat(input logic [7:0] cnt, input int lim);
        sat = (int'(cnt) >= lim);
    endfunction

    seqclk_state_t state;
    seqclk_state_t next_state;
    logic [15:0]   config_reg;
    logic [15:0]   next_config;
    logic [7:0]    adc_select;
    logic [7:0]    next_adc_select;
    logic [7:0]    clock_div;
    logic [7:0]    next_clock_div;
    logic [15:0]   block_powerdown_override;
    logic [15:0]   next_block_powerdown_override;
    logic [7:0]    adc_result;
    logic [7:0]    next_adc_result;
    logic [15:0]   next_rdata;
    logic [7:0]    ticks;
    logic [7:0]    next_ticks;
    logic [7:0]    settle;
    logic [7:0]    next_settle;
    logic          rc_d;
    logic          rc_tick;
    logic          clk_valid;
    logic          next_clk_valid;
    logic          normal;
    logic          next_normal;
    logic          xtal_on;
    logic          testmode;
    seqclk_enables_t seq_en;
    seqclk_enables_t next_en;

    assign rc_tick  = i_rc_clk & ~rc_d;
    assign testmode = config_reg[CFG_TESTMODE_BIT];

    // register file
    always_comb
    begin
        next_config     = config_reg;
        next_adc_select = adc_select;
        next_clock_div  = clock_div;
        next_block_powerdown_override   = block_powerdown_override;
        next_rdata      = 16'h0000;
        if (i_bus.wr)
        begin
            unique case (i_bus.addr)
                ADDR_CONFIG:     next_config     = i_bus.wdata;
                ADDR_ADC_SELECT: next_adc_select = i_bus.wdata[7:0];
                ADDR_CLOCK_DIV:  next_clock_div  = {2'b00, i_bus.wdata[5:0]};
                ADDR_BLOCK_POWERDOWN_OVERRIDE:   next_block_powerdown_override   = i_bus.wdata;
                default:         next_config     = config_reg;
            endcase
        end
        if (i_bus.rd)
        begin
            unique case (i_bus.addr)
                ADDR_CONFIG:     next_rdata = config_reg;
                ADDR_ADC_SELECT: next_rdata = {8'h00, adc_select};
                ADDR_CLOCK_DIV:  next_rdata = {8'h00, clock_div};
                ADDR_BLOCK_POWERDOWN_OVERRIDE:   next_rdata = block_powerdown_override;
                ADDR_ADC_RESULT: next_rdata = {8'h00, adc_result};
                ADDR_SEQ_STATUS: next_rdata = {11'h000, normal, clk_valid,
                                               state};
                default:         next_rdata = 16'h0000;
            endcase
        end
        // sample tagged with conditions that applied to it
        next_adc_result = adc_result;
        if (i_adc_sample)
        begin
            next_adc_result = {~o_enables.adc_en,
                               adc_select[SEL_BIT],
                               i_adc_value};
        end
    end

    // sequencer
    always_comb
    begin
        next_state     = state;
        next_ticks     = ticks;
        next_settle    = settle;
        next_normal    = normal;
        next_clk_valid = clk_valid;
        if (rc_tick && !sat(ticks, 255))
        begin
            next_ticks = ticks + 8'h01;
        end
        unique case (state)
            ST_START:
            begin
                next_ticks = 8'h00;
                next_state = i_powerdown_detect_pin ? ST_WAIT_LOW
                                                    : ST_SETUP;
            end
            ST_WAIT_LOW:
            begin
                next_ticks = 8'h00;
                if (!i_powerdown_detect_pin)
                begin
                    next_state = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // leaving early goes back to ST_WAIT_LOW; the setup time restarts
                if (i_powerdown_detect_pin)
                begin
                    next_state = ST_WAIT_LOW;
                end
                else if (sat(ticks, SYS_SETUP_TICKS))
                begin
                    // pin is low here: go straight on, crystal kept running
                    next_normal = 1'b1;
                    next_ticks  = 8'h00;
                    next_state  = i_rx_mode ? ST_RX_SETUP : ST_TX_SETUP;
                end
            end
            ST_POWERDOWN:
            begin
                next_ticks = 8'h00;
                if (!i_powerdown_detect_pin)
                begin
                    next_state = i_rx_mode ? ST_RX_SETUP : ST_TX_SETUP;
                end
            end
            ST_RX_SETUP:
            begin
                if (i_powerdown_detect_pin)
                begin
                    next_state = ST_POWERDOWN;
                end
                else if (sat(ticks, DETECT_SETUP_TICKS))
                begin
                    next_state = ST_RX;
                end
            end
            ST_TX_SETUP:
            begin
                if (i_powerdown_detect_pin)
                begin
                    next_state = ST_POWERDOWN;
                end
                else if (sat(ticks, TX_SETUP_TICKS))
                begin
                    next_state = ST_TX;
                end
            end
            ST_RX, ST_TX:
            begin
                if (i_powerdown_detect_pin)
                begin
                    next_state = ST_POWERDOWN;
                end
                else if (i_rx_mode != (state == ST_RX))
                begin
                    // direction change without a power-down blip
                    next_ticks = 8'h00;
                    next_state = i_rx_mode ? ST_RX_SETUP : ST_TX_SETUP;
                end
            end
        endcase
        // crystal enable and settle tracking
        xtal_on = (state != ST_POWERDOWN) ||
                  config_reg[CFG_CLK_IN_PD_BIT];
        if (testmode)
        begin
            xtal_on = ~block_powerdown_override[PD_XTAL_BIT];
        end
        if (!xtal_on)
        begin
            next_settle    = 8'h00;
            next_clk_valid = 1'b0;
        end
        else if (rc_tick && !sat(settle, CLOCK_SETTLE_TICKS))
        begin
            next_settle = settle + 8'h01;
        end
        if (xtal_on && sat(settle, CLOCK_SETTLE_TICKS))
        begin
            next_clk_valid = 1'b1;
        end
        next_en.xtal_en   = xtal_on;
        next_en.adc_en    = (state == ST_RX) || (state == ST_RX_SETUP);
        next_en.detect_en = (state == ST_RX);
        next_en.pa_en     = (state == ST_TX);
        next_en.rx_ready  = (state == ST_RX);
        if (testmode)
        begin
            next_en.adc_en    = ~block_powerdown_override[PD_ADC_BIT];
            next_en.detect_en = ~block_powerdown_override[PD_ADC_BIT];
            next_en.pa_en     = ~block_powerdown_override[PD_PA_BIT];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state      <= ST_START;
            config_reg <= CONFIG_RESET;
            adc_select <= ADC_SELECT_RESET;
            clock_div  <= CLOCK_DIV_RESET;
            block_powerdown_override   <= BLOCK_POWERDOWN_OVERRIDE_RESET;
            adc_result <= 8'h00;
            o_rdata    <= 16'h0000;
            ticks      <= 8'h00;
            settle     <= 8'h00;
            rc_d       <= 1'b0;
            clk_valid  <= 1'b0;
            normal     <= 1'b0;
            seq_en     <= '0;
        end
        else
        begin
            state      <= next_state;
            config_reg <= next_config;
            adc_select <= next_adc_select;
            clock_div  <= next_clock_div;
            block_powerdown_override   <= next_block_powerdown_override;
            adc_result <= next_adc_result;
            o_rdata    <= next_rdata;
            ticks      <= next_ticks;
            settle     <= next_settle;
            rc_d       <= i_rc_clk;
            clk_valid  <= next_clk_valid;
            normal     <= next_normal;
            seq_en     <= next_en;
        end
    end

    assign o_enables       = seq_en;
    assign o_clock_valid   = clk_valid;
    assign o_normal_timing = normal;
    assign o_adc_use_rssi  = adc_select[SEL_BIT];

    seqclk_divider u_divider
    (
        .i_clock       (i_clock),
        .i_rst         (i_rst),
        .i_xtal_clk    (i_xtal_clk),
        .i_rc_clk      (i_rc_clk),
        .i_window_done (i_window_done),
        .i_run         (seq_en.xtal_en),
        .i_setting     (clock_div[5:0]),
        .o_clk         (o_divided_clock_pin)
    );
endmodule
`default_nettype wire

/* testbench/seqclk_mcu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module seqclk_mcu_model
#(
    parameter int XH = 2,
    parameter int RH = 5,
    parameter int WH = 7
)
(
    input  wire logic i_clock,
    input  wire logic i_active,
    output logic      o_xtal_clk = 1'b0,
    output logic      o_rc_clk = 1'b0,
    output logic      o_window_done = 1'b0,
    output logic      o_powerdown_detect_pin = 1'b0
);
    int xc = 0;
    int rc = 0;
    int wc = 0;

    // sources seen as sampled levels, each well below half the bus clock
    always @(posedge i_clock)
    begin
        xc <= (xc == XH - 1) ? 0 : xc + 1;
        rc <= (rc == RH - 1) ? 0 : rc + 1;
        wc <= (wc == WH - 1) ? 0 : wc + 1;
        if (xc == XH - 1)
            o_xtal_clk <= !o_xtal_clk;
        if (rc == RH - 1)
            o_rc_clk <= !o_rc_clk;
        if (wc == WH - 1)
            o_window_done <= !o_window_done;
        // detect pin is active inverted, registered on the bus clock
        o_powerdown_detect_pin <= !i_active;
    end
endmodule
`default_nettype wire

/* testbench/seqclk_top_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module seqclk_top_chk
(
    input  wire logic                    i_clock,
    input  wire logic                    i_rst,
    input  wire seqclk_pkg::seqclk_bus_t i_bus,
    input  wire logic [15:0]             o_rdata,
    input  wire logic                    i_powerdown_detect_pin,
    input  wire logic                    i_rx_mode,
    input  wire logic                    o_divided_clock_pin,
    input  wire logic                    o_clock_valid,
    input  wire logic                    o_normal_timing,
    input  wire seqclk_pkg::seqclk_enables_t o_enables,
    input  wire logic                    o_adc_use_rssi
);
    import seqclk_pkg::*;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);

    property p_rdata_idle;
        !$past(i_bus.rd) |-> o_rdata == 16'h0000;
    endproperty
    a_rdata_idle:
        assert property (p_rdata_idle) else $error("read data not idle");
    property p_sel;
        i_bus.wr && i_bus.addr == ADDR_ADC_SELECT
            |=> o_adc_use_rssi == $past(i_bus.wdata[SEL_BIT]);
    endproperty
    a_sel:
        assert property (p_sel) else $error("adc source not updated");
    property p_clk_off;
        !o_enables.xtal_en [*3] |-> !o_divided_clock_pin;
    endproperty
    a_clk_off:
        assert property (p_clk_off) else $error("clock out while xtal off");
    property p_valid_late;
        $rose(o_enables.xtal_en) |-> !o_clock_valid [*8];
    endproperty
    a_valid_late:
        assert property (p_valid_late) else $error("clock valid too early");
    property p_valid_drop;
        $fell(o_enables.xtal_en) |-> ##[0:2] !o_clock_valid;
    endproperty
    a_valid_drop:
        assert property (p_valid_drop) else $error("clock valid kept");
    property p_normal_hold;
        o_normal_timing |=> o_normal_timing;
    endproperty
    a_normal_hold:
        assert property (p_normal_hold) else $error("normal timing lost");
    property p_normal_cause;
        $rose(o_normal_timing) |-> !$past(i_powerdown_detect_pin, 2);
    endproperty
    a_normal_cause:
        assert property (p_normal_cause) else $error("normal while pin high");
    property p_rx_cause;
        $rose(o_enables.rx_ready)
            |-> $past(i_rx_mode, 2) && !$past(i_powerdown_detect_pin, 2);
    endproperty
    a_rx_cause:
        assert property (p_rx_cause) else $error("rx ready without receive");
    property p_no_runt;
        $changed(o_divided_clock_pin) |=> $stable(o_divided_clock_pin);
    endproperty
    a_no_runt:
        assert property (p_no_runt) else $error("runt on clock output");
endmodule
`default_nettype wire

/* testbench/sequencer_and_clock_output_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sequencer_and_clock_output_test;
    import seqclk_pkg::*;
    localparam int RCP = 10;
    logic            i_clock = 1'b0;
    logic            i_rst = 1'b1;
    logic            act = 1'b1;
    logic            rx = 1'b1;
    logic            smp = 1'b0;
    logic [5:0]      val = 6'h00;
    seqclk_bus_t     bus = '0;
    wire logic       xt;
    wire logic       rc;
    wire logic       wd;
    wire logic       pin;
    logic [15:0]     rdata;
    logic            dclk;
    logic            valid;
    logic            normal;
    logic            rssi;
    seqclk_enables_t en;
    int              n_fail = 0;
    int              cmp_count = 0;
    logic [7:0]      dv [6] = '{8'h00, 8'h0f, 8'h10, 8'h20, 8'h30, 8'hc8};
    int              de [6] = '{8, 128, 4, 10, 14, 72};

    seqclk_top dut
    (
        .i_clock                (i_clock),
        .i_rst                  (i_rst),
        .i_bus                  (bus),
        .o_rdata                (rdata),
        .i_powerdown_detect_pin (pin),
        .i_rx_mode              (rx),
        .i_rc_clk               (rc),
        .i_xtal_clk             (xt),
        .i_window_done          (wd),
        .i_adc_sample           (smp),
        .i_adc_value            (val),
        .o_divided_clock_pin    (dclk),
        .o_clock_valid          (valid),
        .o_normal_timing        (normal),
        .o_enables              (en),
        .o_adc_use_rssi         (rssi)
    );
    seqclk_mcu_model mcu
    (
        .i_clock                (i_clock),
        .i_active               (act),
        .o_xtal_clk             (xt),
        .o_rc_clk               (rc),
        .o_window_done          (wd),
        .o_powerdown_detect_pin (pin)
    );

    always #20 i_clock = ~i_clock;

    task automatic end_sim();
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clock);
        bus <= '0;
        @(negedge i_clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge i_clock);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_clock);
        bus <= '0;
        @(negedge i_clock);
        chk("rdata", e, rdata);
    endtask
    task automatic tk(input int n);
        repeat (n * RCP) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    task automatic sample(input logic [5:0] v);
        @(posedge i_clock);
        smp <= 1'b1;
        val <= v;
        @(posedge i_clock);
        smp <= 1'b0;
    endtask
    // period in cycles between the second and third rising output edge
    task automatic per(input int e);
        int r;
        int c;
        int t;
        logic p;
        r = 0;
        c = 0;
        t = 0;
        p = dclk;
        for (int i = 0; i < 800; i++)
        begin
            @(negedge i_clock);
            if (!p && dclk)
            begin
                r++;
                if (r == 3)
                    c = i - t;
                t = i;
            end
            p = dclk;
        end
        chk("period", e[15:0], c[15:0]);
    endtask

    initial
    begin
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        tk(14);
        chk("valid", 0, valid);
        tk(4);
        chk("valid", 1, valid);
        chk("rssi", 1, rssi);
        rd(8'h00, 16'h0000);
        rd(8'h08, 16'h00ff);
        rd(8'h0d, 16'h0008);
        rd(8'h0f, 16'hffff);
        rd(8'h81, 16'h0000);
        rd(8'h40, 16'h0000);
        tk(60);
        chk("normal", 0, normal);
        tk(8);
        chk("normal", 1, normal);
        tk(72);
        chk("detect", 0, en.detect_en);
        tk(12);
        chk("detect", 1, en.detect_en);
        chk("rxready", 1, en.rx_ready);
        per(72);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h0d, {8'h00, dv[i]});
            per(de[i]);
        end
        rd(8'h0d, 16'h0008);
        @(posedge i_clock);
        rx <= 1'b0;
        tk(28);
        chk("pa", 0, en.pa_en);
        tk(8);
        chk("pa", 1, en.pa_en);
        chk("rxready", 0, en.rx_ready);
        @(posedge i_clock);
        act <= 1'b0;
        tk(2);
        per(0);
        chk("valid", 0, valid);
        wr(8'h00, 16'h0200);
        per(72);
        wr(8'h00, 16'h0001);
        wr(8'h0f, 16'hfffb);
        tk(1);
        chk("pa", 1, en.pa_en);
        wr(8'h0f, 16'hefff);
        tk(1);
        chk("adc", 1, en.adc_en);
        chk("pa", 0, en.pa_en);
        sample(6'h2a);
        rd(8'h81, 16'h006a);
        wr(8'h08, 16'h00bf);
        chk("rssi", 0, rssi);
        wr(8'h0f, 16'hffff);
        tk(1);
        sample(6'h15);
        rd(8'h81, 16'h0095);
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        rx <= 1'b1;
        tk(100);
        chk("normal", 0, normal);
        per(72);
        @(posedge i_clock);
        act <= 1'b1;
        tk(80);
        chk("normal", 0, normal);
        tk(8);
        chk("normal", 1, normal);
        end_sim();
    end

    initial
    begin
        repeat (40000) @(posedge i_clock);
        n_fail++;
        end_sim();
    end
endmodule

bind seqclk_top seqclk_top_chk chk
(
    .i_clock                (i_clock),
    .i_rst                  (i_rst),
    .i_bus                  (i_bus),
    .o_rdata                (o_rdata),
    .i_powerdown_detect_pin (i_powerdown_detect_pin),
    .i_rx_mode              (i_rx_mode),
    .o_divided_clock_pin    (o_divided_clock_pin),
    .o_clock_valid          (o_clock_valid),
    .o_normal_timing        (o_normal_timing),
    .o_enables              (o_enables),
    .o_adc_use_rssi         (o_adc_use_rssi)
);
`default_nettype wire
